// [peru_pkg.sv]
package peru_pkg;
    // ------------------------------------------------------------
    // register byte offsets (apb, one aligned word each)
    // ------------------------------------------------------------
    localparam logic [7:0] PERU_OFS_CSR = 8'h00;
    localparam logic [7:0] PERU_OFS_ISR = 8'h04;
    localparam logic [7:0] PERU_OFS_IMSK = 8'h08;
    localparam logic [7:0] PERU_OFS_ERRCS = 8'h0c;
    localparam logic [7:0] PERU_OFS_AERR = 8'h10;
    localparam logic [7:0] PERU_OFS_MISC = 8'h14;
    localparam logic [7:0] PERU_OFS_DMA = 8'h18;
    // ------------------------------------------------------------
    // pci_command_status_reg fields
    // ------------------------------------------------------------
    localparam int PERU_CSR_PARITY_ERROR_RESPONSE = 6;
    localparam int PERU_CSR_SERREN = 8;
    localparam int PERU_CSR_MDPD = 24;
    localparam int PERU_CSR_STA = 27;
    localparam int PERU_CSR_RTA = 28;
    localparam int PERU_CSR_RMA = 29;
    localparam int PERU_CSR_SSERR = 30;
    localparam int PERU_CSR_DPE = 31;
    // ------------------------------------------------------------
    // interrupt_status_one fields
    // ------------------------------------------------------------
    localparam int PERU_ISR_CPU_ERR = 0;
    localparam int PERU_ISR_OTH_ERR = 1;
    localparam int PERU_ISR_SAME_ERR = 2;
    localparam int PERU_ISR_CPU_RTY = 3;
    localparam int PERU_ISR_OTH_RTY = 4;
    localparam int PERU_ISR_SAME_RTY = 5;
    localparam int PERU_ISR_APAR = 6;
    localparam int PERU_ISR_DMA = 7;
    localparam int PERU_ISR_W = 8;
    // misc register and error log control fields
    localparam int PERU_MISC_CAM = 0;
    localparam int PERU_ERRCS_ES = 31;
    localparam logic [31:0] PERU_RST_ZERO = 32'h0000_0000;
    localparam logic [31:0] PERU_ALL_ONES = 32'hffff_ffff;
    // ------------------------------------------------------------
    // error sources and termination kinds
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PERU_SRC_CPU = 2'b00,
        PERU_SRC_OTHER = 2'b01,
        PERU_SRC_SAME = 2'b10
    } peru_src_t;
    typedef enum logic [1:0] {
        PERU_TERM_OK = 2'b00,
        PERU_TERM_MA = 2'b01,
        PERU_TERM_TA = 2'b10,
        PERU_TERM_RETRY = 2'b11
    } peru_term_t;
endpackage

// [peru_unit.sv]
// How it works
// - master abort sets status and source flag
// - retry expiry sets per-source retry flag
// - latch read error, report on return
// - returned latched error gets target abort
// - received target abort sets status, flag
// - target-reported write parity sets master parity
// - perr only with parity response set
// - serr needs parity response and enable
// - config master abort: ones or target abort
// - error bits never stall forwarding
// - address parity still claimed and completed
// - target data parity proceeds normally
// - read parity error continues, parity regenerated
// - failed write purged, dma status posted
// - failed read latched for source
// - dma flags per bus interface
// - dma flags can raise interrupt
// - clearing status flag drops interrupt
// - new log only after lock cleared
// - dma stays stopped until flag cleared
// - distinct flags per pci error kind
// - log command and address per error
// - address parity serr, parity, flag
//
// Local design decisions: the APB slave port and the register offsets.
module peru_unit
    import peru_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic mst_done,
    input wire logic mst_write,
    input wire peru_pkg::peru_src_t mst_src,
    input wire peru_pkg::peru_term_t mst_term,
    input wire logic mst_dma,
    input wire logic mst_wr_perr,
    input wire logic mst_rd_perr,
    input wire logic [3:0] mst_cmd,
    input wire logic [31:0] mst_addr,
    input wire logic far_rd_err,
    input wire peru_pkg::peru_src_t far_src,
    input wire logic far_cfg_ma,
    input wire logic tgt_return,
    input wire logic [3:0] tgt_cmd,
    input wire logic [31:0] tgt_addr,
    input wire logic tgt_addr_perr,
    input wire logic tgt_data_perr,
    input wire peru_pkg::peru_src_t tgt_dst,
    input wire logic [31:0] rd_data_in,
    output logic tgt_claim,
    output logic tgt_abort,
    output logic [31:0] tgt_rd_data,
    output logic tgt_rd_par,
    output logic mst_stop,
    output logic purge,
    output logic dma_err_post,
    output logic perr_n_out,
    output logic perr_oe,
    output logic serr_n_out,
    output logic serr_oe,
    input wire logic [2:0] dma_bus_err,
    input wire logic dma_restart,
    output logic dma_run_ok,
    output logic irq
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] csr;
        logic [PERU_ISR_W-1:0] isr;
        logic [PERU_ISR_W-1:0] imsk;
        logic [31:0] errcs;
        logic [31:0] aerr;
        logic [31:0] misc;
        logic [2:0] dma;
        logic rd_err_pend;
        logic rd_err_cfg;
        peru_src_t rd_err_src;
        logic [31:0] rdata;
        logic abort;
        logic [31:0] tdata;
        logic tpar;
        logic stop;
        logic purge;
        logic dpost;
        logic perr;
        logic serr;
    } peru_state_t;

    peru_state_t cur;
    peru_state_t next_cur;

    // maps a source to its interface error flag position
    function automatic int peru_err_bit(input peru_src_t s);
        return (s == PERU_SRC_CPU) ? PERU_ISR_CPU_ERR :
               (s == PERU_SRC_OTHER) ? PERU_ISR_OTH_ERR : PERU_ISR_SAME_ERR;
    endfunction

    // write-one-to-clear with hardware set winning the same cycle
    function automatic logic [31:0] peru_w1c(input logic [31:0] v, input logic [31:0] c, input logic [31:0] s);
        return (v & ~c) | s;
    endfunction

    logic wr_en;
    logic rd_en;
    logic mapped;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign mapped = paddr inside {PERU_OFS_CSR, PERU_OFS_ISR, PERU_OFS_IMSK, PERU_OFS_ERRCS,
                                  PERU_OFS_AERR, PERU_OFS_MISC, PERU_OFS_DMA};

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [31:0] csr_set;
        logic [PERU_ISR_W-1:0] isr_set;
        logic [31:0] wclr;
        logic log_ev;
        logic mst_fail;
        logic [3:0] log_cmd;
        logic [31:0] log_addr;
        logic perresp;
        logic serren;
        csr_set = PERU_RST_ZERO;
        isr_set = '0;
        wclr = PERU_RST_ZERO;
        log_ev = 1'b0;
        log_cmd = tgt_cmd;
        log_addr = tgt_addr;
        next_cur = cur;
        perresp = cur.csr[PERU_CSR_PARITY_ERROR_RESPONSE];
        serren = cur.csr[PERU_CSR_SERREN];
        mst_fail = mst_done && (mst_term != PERU_TERM_OK);
        next_cur.abort = 1'b0;
        next_cur.stop = 1'b0;
        next_cur.purge = 1'b0;
        next_cur.dpost = 1'b0;
        next_cur.perr = 1'b0;
        next_cur.serr = 1'b0;
        // read data regenerated with fresh parity whatever the bus parity was
        next_cur.tdata = rd_data_in;
        next_cur.tpar = ^rd_data_in;

        // master terminations
        if (mst_fail)
        begin
            next_cur.stop = 1'b1;
            log_ev = 1'b1;
            log_cmd = mst_cmd;
            log_addr = mst_addr;
            unique case (mst_term)
                PERU_TERM_MA:
                begin
                    csr_set[PERU_CSR_RMA] = 1'b1;
                    isr_set[peru_err_bit(mst_src)] = 1'b1;
                end
                PERU_TERM_TA:
                begin
                    csr_set[PERU_CSR_RTA] = 1'b1;
                    isr_set[peru_err_bit(mst_src)] = 1'b1;
                end
                PERU_TERM_RETRY:
                    isr_set[PERU_ISR_CPU_RTY + int'(mst_src)] = 1'b1;
                default:
                    isr_set = isr_set;
            endcase
            if (mst_write)
            begin
                next_cur.purge = 1'b1;
                next_cur.dpost = mst_dma;
            end
        end
        // external target flagged parity on our write
        if (mst_done && mst_write && mst_wr_perr)
            csr_set[PERU_CSR_MDPD] = 1'b1;
        // read data parity seen by our master: flag, read still proceeds
        if (mst_done && !mst_write && mst_rd_perr)
        begin
            csr_set[PERU_CSR_DPE] = 1'b1;
            isr_set[peru_err_bit(mst_src)] = 1'b1;
            next_cur.perr = perresp;
            csr_set[PERU_CSR_MDPD] = perresp;
            log_ev = 1'b1;
            log_cmd = mst_cmd;
            log_addr = mst_addr;
        end

        // far master read error latched until requester returns
        if (far_rd_err)
        begin
            next_cur.rd_err_pend = 1'b1;
            next_cur.rd_err_cfg = far_cfg_ma;
            next_cur.rd_err_src = far_src;
        end
        next_cur.rdata = rd_data_in;
        if (tgt_return && cur.rd_err_pend)
        begin
            next_cur.rd_err_pend = far_rd_err;
            if (cur.rd_err_cfg && cur.misc[PERU_MISC_CAM])
                next_cur.rdata = PERU_ALL_ONES;
            else
            begin
                next_cur.abort = 1'b1;
                csr_set[PERU_CSR_STA] = 1'b1;
                isr_set[peru_err_bit(cur.rd_err_src)] = 1'b1;
                log_ev = 1'b1;
            end
        end
        next_cur.tdata = next_cur.rdata;
        next_cur.tpar = ^next_cur.rdata;

        // target parity: flagged, transaction carries on
        if (tgt_addr_perr)
        begin
            csr_set[PERU_CSR_DPE] = 1'b1;
            isr_set[PERU_ISR_APAR] = 1'b1;
            next_cur.serr = perresp && serren;
            csr_set[PERU_CSR_SSERR] = perresp && serren;
            log_ev = 1'b1;
        end
        if (tgt_data_perr)
        begin
            csr_set[PERU_CSR_DPE] = 1'b1;
            isr_set[peru_err_bit(tgt_dst)] = 1'b1;
            next_cur.perr = perresp;
            log_ev = 1'b1;
        end

        // dma per-interface fault flags, sticky until software clears
        next_cur.dma = cur.dma | dma_bus_err;
        isr_set[PERU_ISR_DMA] = |dma_bus_err;

        // software writes
        if (wr_en)
            wclr = pwdata;
        unique case (paddr)
            PERU_OFS_CSR:
            begin
                next_cur.csr = peru_w1c(cur.csr, wr_en ? (wclr & 32'hff00_0000) : PERU_RST_ZERO, csr_set);
                if (wr_en)
                    next_cur.csr[15:0] = pwdata[15:0];
            end
            default:
                next_cur.csr = cur.csr | csr_set;
        endcase
        next_cur.isr = cur.isr | isr_set;
        if (wr_en && paddr == PERU_OFS_ISR)
            next_cur.isr = (cur.isr & ~pwdata[PERU_ISR_W-1:0]) | isr_set;
        if (wr_en && paddr == PERU_OFS_IMSK)
            next_cur.imsk = pwdata[PERU_ISR_W-1:0];
        if (wr_en && paddr == PERU_OFS_MISC)
            next_cur.misc = pwdata & 32'h0000_0001;
        if (wr_en && paddr == PERU_OFS_DMA)
            next_cur.dma = (cur.dma & ~pwdata[2:0]) | dma_bus_err;
        if (wr_en && paddr == PERU_OFS_ERRCS && pwdata[PERU_ERRCS_ES])
            next_cur.errcs[PERU_ERRCS_ES] = 1'b0;

        // error log: captured only while unlocked
        if (log_ev && !cur.errcs[PERU_ERRCS_ES])
        begin
            next_cur.errcs = {1'b1, 27'h0, log_cmd};
            next_cur.aerr = log_addr;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cur <= '0;
        else
            cur <= next_cur;
    end

    // read mux and fixed one-cycle access phase
    always_comb
    begin
        unique case (paddr)
            PERU_OFS_CSR: prdata = cur.csr;
            PERU_OFS_ISR: prdata = {24'h0, cur.isr};
            PERU_OFS_IMSK: prdata = {24'h0, cur.imsk};
            PERU_OFS_ERRCS: prdata = cur.errcs;
            PERU_OFS_AERR: prdata = cur.aerr;
            PERU_OFS_MISC: prdata = cur.misc;
            PERU_OFS_DMA: prdata = {29'h0, cur.dma};
            default: prdata = PERU_RST_ZERO;
        endcase
        if (!rd_en)
            prdata = PERU_RST_ZERO;
    end
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // error flags never gate claiming or forwarding
    assign tgt_claim = 1'b1;
    assign tgt_abort = cur.abort;
    assign tgt_rd_data = cur.tdata;
    assign tgt_rd_par = cur.tpar;
    assign mst_stop = cur.stop;
    assign purge = cur.purge;
    assign dma_err_post = cur.dpost;
    assign perr_n_out = 1'b0;
    assign perr_oe = cur.perr;
    assign serr_n_out = 1'b0;
    assign serr_oe = cur.serr;
    assign dma_run_ok = (cur.dma == 3'b000) && dma_restart;
    assign irq = |(cur.isr & cur.imsk);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_ma_status: assert property (@(posedge pclk) disable iff (!presetn)
        mst_done && mst_term == PERU_TERM_MA |=> cur.csr[PERU_CSR_RMA])
        else $error("master abort not recorded");
    a_retry_flag: assert property (@(posedge pclk) disable iff (!presetn)
        mst_done && mst_term == PERU_TERM_RETRY && mst_src == PERU_SRC_SAME |=> cur.isr[PERU_ISR_SAME_RTY])
        else $error("retry expiry flag missing");
    a_ta_return: assert property (@(posedge pclk) disable iff (!presetn)
        tgt_return && cur.rd_err_pend && !(cur.rd_err_cfg && cur.misc[PERU_MISC_CAM])
        |=> tgt_abort && cur.csr[PERU_CSR_STA])
        else $error("latched read error not aborted");
    a_cfg_ones: assert property (@(posedge pclk) disable iff (!presetn)
        tgt_return && cur.rd_err_pend && cur.rd_err_cfg && cur.misc[PERU_MISC_CAM]
        |=> !tgt_abort && tgt_rd_data == PERU_ALL_ONES)
        else $error("config abort mapping wrong");
    a_rta_status: assert property (@(posedge pclk) disable iff (!presetn)
        mst_done && mst_term == PERU_TERM_TA |=> cur.csr[PERU_CSR_RTA] && mst_stop)
        else $error("target abort not recorded");
    a_perr_gate: assert property (@(posedge pclk) disable iff (!presetn)
        perr_oe |-> $past(cur.csr[PERU_CSR_PARITY_ERROR_RESPONSE]))
        else $error("perr driven without enable");
    a_serr_gate: assert property (@(posedge pclk) disable iff (!presetn)
        serr_oe |-> $past(cur.csr[PERU_CSR_PARITY_ERROR_RESPONSE]) && $past(cur.csr[PERU_CSR_SERREN]))
        else $error("serr driven without enables");
    a_write_purge: assert property (@(posedge pclk) disable iff (!presetn)
        mst_done && mst_write && mst_term != PERU_TERM_OK |=> purge)
        else $error("failed write not purged");
    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        irq && !(wr_en && (paddr == PERU_OFS_ISR || paddr == PERU_OFS_IMSK)) |=> irq)
        else $error("interrupt dropped while flag set");
    a_log_lock: assert property (@(posedge pclk) disable iff (!presetn)
        cur.errcs[PERU_ERRCS_ES] && !(wr_en && paddr == PERU_OFS_ERRCS) |=> $stable(cur.aerr))
        else $error("locked error log overwritten");
    a_mdpd_write: assert property (@(posedge pclk) disable iff (!presetn)
        mst_done && mst_write && mst_wr_perr |=> cur.csr[PERU_CSR_MDPD])
        else $error("write parity report not recorded");
    a_dma_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (|dma_bus_err) |=> cur.dma != 3'b000 && !dma_run_ok)
        else $error("dma channel not held stopped");
    a_apar_flag: assert property (@(posedge pclk) disable iff (!presetn)
        tgt_addr_perr |=> cur.csr[PERU_CSR_DPE] && cur.isr[PERU_ISR_APAR])
        else $error("address parity not flagged");
    c_ma: cover property (@(posedge pclk) mst_done && mst_term == PERU_TERM_MA);
    c_abort: cover property (@(posedge pclk) tgt_abort);
    c_serr: cover property (@(posedge pclk) serr_oe);
    c_irq: cover property (@(posedge pclk) $fell(irq));
    c_cfg_ones: cover property (@(posedge pclk)
        tgt_return && cur.rd_err_pend && cur.rd_err_cfg && cur.misc[PERU_MISC_CAM]);
endmodule // peru_unit

// [peru_pci_agent.sv]
module peru_pci_agent
    import peru_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic req,
    input wire logic [3:0] dly,
    input wire logic [7:0] op,
    input wire logic [35:0] cmd_addr,
    output logic mst_done,
    output logic mst_write,
    output peru_pkg::peru_src_t mst_src,
    output peru_pkg::peru_term_t mst_term,
    output logic mst_dma,
    output logic mst_wr_perr,
    output logic mst_rd_perr,
    output logic [3:0] mst_cmd,
    output logic [31:0] mst_addr
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt;
    logic busy;
    logic [7:0] f;
    // ------------------------------------------------------------
    // far target ending our master's transfer after a set wait
    // ------------------------------------------------------------
    // a slow target stretches the wait so event timing is never fixed
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy <= 1'b0;
            cnt <= 4'h0;
            f <= 8'h00;
            mst_done <= 1'b0;
            mst_cmd <= 4'h0;
            mst_addr <= 32'h0000_0000;
        end
        else if (req)
        begin
            busy <= 1'b1;
            cnt <= dly;
            f <= op;
            mst_cmd <= cmd_addr[35:32];
            mst_addr <= cmd_addr[31:0];
        end
        else if (busy && cnt != 4'h0)
            cnt <= cnt - 4'h1;
        else if (busy)
        begin
            busy <= 1'b0;
            mst_done <= 1'b1;
        end
        else if (mst_done)
        begin
            // fields mean nothing after the pulse, so scramble them
            mst_done <= 1'b0;
            mst_cmd <= ~mst_cmd;
            mst_addr <= ~mst_addr;
        end
    end
    // termination code and parity report of the far party
    assign mst_term = peru_term_t'(f[1:0]);
    assign mst_src = peru_src_t'(f[3:2]);
    assign mst_write = f[4];
    assign mst_dma = f[5];
    assign mst_wr_perr = f[6];
    assign mst_rd_perr = f[7];
endmodule // peru_pci_agent

// [pci_error_reporting_unit_tb.sv]
module pci_error_reporting_unit_tb;
    import peru_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, req, lsv;
    logic [7:0] paddr, op;
    logic [31:0] pwdata, prdata, mst_addr, tgt_addr, rd_data_in, tgt_rd_data, q;
    logic mst_done, mst_write, mst_dma, mst_wr_perr, mst_rd_perr, far_rd_err, far_cfg_ma, tgt_return;
    logic tgt_addr_perr, tgt_data_perr, tgt_claim, tgt_abort, tgt_rd_par, mst_stop, purge, dma_err_post;
    logic perr_n_out, perr_oe, serr_n_out, serr_oe, dma_restart, dma_run_ok, irq;
    logic [3:0] mst_cmd, tgt_cmd, dly;
    logic [2:0] dma_bus_err;
    logic [35:0] cmd_addr;
    peru_src_t mst_src, far_src, tgt_dst;
    peru_term_t mst_term;
    integer seed;
    int miscompares, n_tests, cyc, m_csr, m_isr, m_es, m_errcs, m_aerr, en;
    peru_unit u_dut (.*);
    peru_pci_agent u_far (.*);
    // ------------------------------------------------------------
    // clock, hang guard and verdict
    // ------------------------------------------------------------
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // the whole run needs a few hundred cycles; far beyond that is a hang
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            miscompares++;
            print_verdict();
        end
    end
    task print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
        n_tests++;
        if (seen !== want)
        begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", nm, want, seen);
        end
    endtask
    // ------------------------------------------------------------
    // apb master: holds the request until pready is seen high
    // ------------------------------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        r = prdata;
        lsv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, q);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] want);
        apb(1'b0, a, 32'h0000_0000, q);
        chk(nm, q, want);
    endtask
    // ------------------------------------------------------------
    // events with the reference model kept in integers
    // ------------------------------------------------------------
    task automatic mop(input logic [7:0] o, input logic [35:0] ca);
        int e;
        @(posedge pclk);
        req <= 1'b1;
        op <= o;
        cmd_addr <= ca;
        dly <= 4'($random(seed)) & 4'h7;
        @(posedge pclk);
        req <= 1'b0;
        do
        begin
            @(posedge pclk);
        end
        while (mst_done !== 1'b1);
        #1;
        e = (o[1:0] != 2'b00);
        chk("mst_stop", mst_stop, e);
        chk("purge", purge, e & o[4]);
        chk("dma_err_post", dma_err_post, e & o[4] & o[5]);
        chk("perr_rd", perr_oe, o[7] & !o[4] & m_csr[PERU_CSR_PARITY_ERROR_RESPONSE]);
        if (o[7] && !o[4])
        begin
            m_csr |= 1 << PERU_CSR_DPE | m_csr[PERU_CSR_PARITY_ERROR_RESPONSE] << PERU_CSR_MDPD;
            m_isr |= 1 << o[3:2];
        end
        if (o[1:0] == 2'b11)
            m_isr |= 1 << (3 + o[3:2]);
        else if (e)
        begin
            m_isr |= 1 << o[3:2];
            m_csr |= 1 << (o[1] ? PERU_CSR_RTA : PERU_CSR_RMA);
        end
        if ((e || (o[7] && !o[4])) && m_es == 0)
        begin
            m_es = 1;
            m_errcs = 32'h8000_0000 | ca[35:32];
            m_aerr = ca[31:0];
        end
    endtask
    task automatic tret(input logic [1:0] fs, input logic fe, input logic cm, input logic mp);
        logic [31:0] d;
        logic ab;
        d = $random(seed);
        @(posedge pclk);
        far_rd_err <= fe;
        far_src <= peru_src_t'(fs);
        far_cfg_ma <= cm;
        tgt_cmd <= 4'($random(seed));
        tgt_addr <= $random(seed);
        @(posedge pclk);
        far_rd_err <= 1'b0;
        tgt_return <= 1'b1;
        rd_data_in <= d;
        @(posedge pclk);
        tgt_return <= 1'b0;
        #1;
        ab = fe && !(cm && mp);
        chk("tgt_abort", tgt_abort, ab);
        chk("tgt_claim", tgt_claim, 1);
        if (!ab)
            chk("tgt_rd_data", tgt_rd_data, (cm && fe) ? 32'hffff_ffff : d);
        if (!fe)
            chk("tgt_rd_par", tgt_rd_par, ^d);
        if (ab)
        begin
            m_csr |= 1 << PERU_CSR_STA;
            m_isr |= 1 << fs;
        end
    endtask
    task automatic pev(input logic ap, input int k);
        logic ds;
        ds = 1'($random(seed));
        @(posedge pclk);
        tgt_addr_perr <= ap;
        tgt_data_perr <= !ap;
        tgt_dst <= peru_src_t'({1'b0, ds});
        @(posedge pclk);
        tgt_addr_perr <= 1'b0;
        tgt_data_perr <= 1'b0;
        #1;
        chk("perr_oe", perr_oe, !ap && k[0]);
        chk("serr_oe", serr_oe, ap && k == 3);
        chk("pins_low", {perr_n_out, serr_n_out}, 0);
        m_csr |= (ap && k == 3) << PERU_CSR_SSERR | 1 << PERU_CSR_DPE;
        m_isr |= 1 << (ap ? PERU_ISR_APAR : ds);
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        seed = 32'h7806da4b;
        presetn = 1'b0;
        {psel, penable, pwrite, req, far_rd_err, far_cfg_ma, tgt_return, tgt_addr_perr, tgt_data_perr} = '0;
        {paddr, pwdata, op, dly, cmd_addr, tgt_cmd, tgt_addr, rd_data_in, dma_bus_err, dma_restart} = '0;
        far_src = PERU_SRC_CPU;
        tgt_dst = PERU_SRC_CPU;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a < 8'h1c; a += 4)
            rdc("reset_value", 8'(a), 0);
        apb(1'b1, 8'h1c, 32'hffff_ffff, q);
        rdc("unmapped", 8'h1c, 0);
        chk("pslverr", lsv, 1);
        wr(PERU_OFS_IMSK, 32'h0000_00ff);
        rdc("imsk", PERU_OFS_IMSK, 32'h0000_00ff);
        // every termination from every source, reads and writes back to back
        for (int i = 0; i < 24; i++)
        begin
            mop({2'b00, 1'($random(seed)), i[0], 2'((i >> 1) % 3), 2'(i / 6)}, 36'($random(seed)));
            rdc("csr", PERU_OFS_CSR, m_csr);
            rdc("isr", PERU_OFS_ISR, m_isr);
            chk("irq", irq, m_isr != 0);
        end
        rdc("errcs", PERU_OFS_ERRCS, m_errcs);
        rdc("aerr", PERU_OFS_AERR, m_aerr);
        wr(PERU_OFS_ERRCS, 32'h8000_0000);
        m_es = 0;
        mop(8'h01, {4'h6, $random(seed)});
        rdc("errcs_new", PERU_OFS_ERRCS, m_errcs);
        rdc("aerr_new", PERU_OFS_AERR, m_aerr);
        wr(PERU_OFS_IMSK, 0);
        #1;
        chk("irq_masked", irq, 0);
        wr(PERU_OFS_IMSK, 32'h0000_00ff);
        // latched far read errors, then a clean return after them
        for (int i = 0; i < 5; i++)
            tret(2'(i % 2), i[1] & !i[2], 1'b0, 1'b0);
        rdc("csr_sta", PERU_OFS_CSR, m_csr);
        rdc("isr_sta", PERU_OFS_ISR, m_isr);
        wr(PERU_OFS_MISC, 1);
        rdc("misc", PERU_OFS_MISC, 1);
        tret(2'b01, 1'b1, 1'b1, 1'b1);
        wr(PERU_OFS_MISC, 0);
        tret(2'b01, 1'b1, 1'b1, 1'b0);
        mop(8'h50, 36'($random(seed)));
        apb(1'b0, PERU_OFS_CSR, 0, q);
        chk("mdpd", q[PERU_CSR_MDPD], 1);
        wr(PERU_OFS_CSR, 32'hff00_0000);
        wr(PERU_OFS_ISR, 32'h0000_00ff);
        #1;
        chk("irq_cleared", irq, 0);
        m_csr = 0;
        m_isr = 0;
        // parity reports under every enable pair
        for (int k = 0; k < 4; k++)
        begin
            en = (k & 1) << PERU_CSR_PARITY_ERROR_RESPONSE | (k >> 1) << PERU_CSR_SERREN;
            wr(PERU_OFS_CSR, en);
            m_csr = m_csr & 32'hffff_0000 | en;
            pev(1'b0, k);
            pev(1'b1, k);
            mop(8'h88, 36'($random(seed)));
            rdc("csr_par", PERU_OFS_CSR, m_csr);
            rdc("isr_par", PERU_OFS_ISR, m_isr);
        end
        wr(PERU_OFS_ISR, 32'h0000_00ff);
        dma_restart <= 1'b1;
        // each dma bus flag stops the channel until cleared
        for (int b = 0; b < 3; b++)
        begin
            @(posedge pclk);
            dma_bus_err <= 3'(1 << b);
            @(posedge pclk);
            dma_bus_err <= 3'h0;
            #1;
            chk("run_ok_stopped", dma_run_ok, 0);
            chk("irq_dma", irq, 1);
            rdc("dma_flags", PERU_OFS_DMA, 1 << b);
            wr(PERU_OFS_DMA, 1 << b);
            wr(PERU_OFS_ISR, 1 << PERU_ISR_DMA);
            #1;
            chk("run_ok_again", dma_run_ok, 1);
            chk("irq_dma_clr", irq, 0);
        end
        print_verdict();
    end
endmodule // pci_error_reporting_unit_tb
